//--- design/mrx_exec.sv
// Executor for the six memory-reference instructions and interrupt enable control.
`timescale 1ns/10ps
module mrx_exec #(
  parameter int CYC_SHORT = mrx_pkg::CYC_SHORT,
  parameter int CYC_MID   = mrx_pkg::CYC_MID,
  parameter int CYC_LONG  = mrx_pkg::CYC_LONG
) (
  // Clock, reset and enable.
  input  wire logic        i_mclk,
  input  wire logic        i_resetn,
  input  wire logic        i_ce,
  // Instruction request.
  input  wire logic        i_start,
  input  wire logic [11:0] i_instr,
  input  wire logic [11:0] i_addr_y,
  output logic             o_busy,
  output logic             o_done,
  // Core memory side.
  output logic [11:0]      o_mem_addr,
  output logic [11:0]      o_mem_wdata,
  output logic             o_mem_rd,
  output logic             o_mem_wr,
  input  wire logic [11:0] i_mem_rdata,
  // Interrupt request pin and its acceptance.
  input  wire logic        i_int_req,
  output logic             o_int_take,
  output logic             o_int_en,
  // Processor state.
  output logic [11:0]      o_accumulator_reg,
  output logic [11:0]      o_program_counter_reg
);
  logic             rst_meta_r;
  logic             rst_n_r;
  logic             int_req_s;
  mrx_pkg::mrx_state_t state_r;
  logic [2:0]       op_r;
  logic [11:0]      y_r;
  logic [11:0]      acc_r;
  logic [11:0]      prog_cnt_r;
  logic [11:0]      wdata_r;
  logic [11:0]      mbuf_r;
  logic             int_en_r;
  logic [15:0]      cnt_r;
  logic [15:0]      len_r;

  // Execution time for an operation code.
  function automatic logic [15:0] op_cycles(input logic [2:0] op);
    if (op == mrx_pkg::OP_CALL) begin
      op_cycles = 16'(CYC_LONG);
    end else if (op == mrx_pkg::OP_JUMP) begin
      op_cycles = 16'(CYC_SHORT);
    end else begin
      op_cycles = 16'(CYC_MID);
    end
  endfunction

  // Reset release through two flip-flops.
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // The interrupt level comes from outside and is synchronised.
  mrx_sync u_int_sync (
    .i_mclk  (i_mclk),
    .i_rst_n (rst_n_r),
    .i_ce    (i_ce),
    .i_async (i_int_req),
    .o_sync  (int_req_s)
  );

  // Phase sequencer with a cycle counter that sets each instruction's time.
  always_ff @(posedge i_mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= mrx_pkg::ST_IDLE;
      op_r    <= 3'h0;
      y_r     <= 12'h000;
      cnt_r   <= 16'h0000;
      len_r   <= 16'h0000;
    end else if (i_ce) begin
      case (state_r)
        mrx_pkg::ST_IDLE: begin
          if (i_start && i_instr[11:9] <= mrx_pkg::OP_JUMP) begin
            op_r    <= i_instr[11:9];
            y_r     <= i_addr_y;
            len_r   <= op_cycles(i_instr[11:9]);
            // The counter holds the index of the current cycle, so done lands in cycle len-1.
            cnt_r   <= 16'h0000;
            state_r <= mrx_pkg::ST_READ;
          end
        end
        mrx_pkg::ST_READ: begin
          cnt_r   <= cnt_r + 16'h0001;
          state_r <= mrx_pkg::ST_WRITE;
        end
        mrx_pkg::ST_WRITE: begin
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_r + 16'h0001 >= len_r - 16'h0001) begin
            state_r <= mrx_pkg::ST_DONE;
          end
        end
        default: begin
          state_r <= mrx_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Memory buffer captures the operand during the read phase.
  always_ff @(posedge i_mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      mbuf_r <= 12'h000;
    end else if (i_ce && state_r == mrx_pkg::ST_READ) begin
      mbuf_r <= i_mem_rdata;
    end
  end

  // Accumulator updates once, at the end of the instruction.
  always_ff @(posedge i_mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      acc_r <= mrx_pkg::ACC_RST;
    end else if (i_ce && state_r == mrx_pkg::ST_DONE) begin
      case (op_r)
        mrx_pkg::OP_AND:       acc_r <= acc_r & mbuf_r;
        mrx_pkg::OP_ADD:       acc_r <= acc_r + mbuf_r;
        mrx_pkg::OP_STORE_CLR: acc_r <= 12'h000;
        default:               acc_r <= acc_r;
      endcase
    end
  end

  // Program counter: normal advance, skip, subroutine and jump.
  always_ff @(posedge i_mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      prog_cnt_r <= mrx_pkg::PROG_CNT_RST;
    end else if (i_ce && state_r == mrx_pkg::ST_DONE) begin
      case (op_r)
        mrx_pkg::OP_INC_SKIP: begin
          if (mbuf_r + 12'h001 == 12'h000) begin
            prog_cnt_r <= prog_cnt_r + 12'h002;
          end else begin
            prog_cnt_r <= prog_cnt_r + 12'h001;
          end
        end
        mrx_pkg::OP_CALL: prog_cnt_r <= y_r + 12'h001;
        mrx_pkg::OP_JUMP: prog_cnt_r <= y_r;
        default:          prog_cnt_r <= prog_cnt_r + 12'h001;
      endcase
    end
  end

  // Interrupt enable follows the on and off transfer codes.
  always_ff @(posedge i_mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      int_en_r <= 1'b0;
    end else if (i_ce && i_start && state_r == mrx_pkg::ST_IDLE) begin
      if (i_instr == mrx_pkg::XFER_INT_ON) begin
        int_en_r <= 1'b1;
      end else if (i_instr == mrx_pkg::XFER_INT_OFF) begin
        int_en_r <= 1'b0;
      end
    end
  end

  // Write data is loaded in the wait cycles, so it stands steady from a flop with the strobe.
  always_ff @(posedge i_mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      wdata_r <= 12'h000;
    end else if (i_ce && state_r == mrx_pkg::ST_WRITE) begin
      case (op_r)
        mrx_pkg::OP_INC_SKIP:  wdata_r <= mbuf_r + 12'h001;
        mrx_pkg::OP_STORE_CLR: wdata_r <= acc_r;
        mrx_pkg::OP_CALL:      wdata_r <= prog_cnt_r + 12'h001;
        default:               wdata_r <= 12'h000;
      endcase
    end
  end

  // Memory strobes: one read cycle, one write in the final cycle for increment, deposit and subroutine.
  always_comb begin
    o_mem_rd = (state_r == mrx_pkg::ST_READ);
    o_mem_wr = 1'b0;
    if (state_r == mrx_pkg::ST_DONE) begin
      case (op_r)
        mrx_pkg::OP_INC_SKIP:  o_mem_wr = 1'b1;
        mrx_pkg::OP_STORE_CLR: o_mem_wr = 1'b1;
        mrx_pkg::OP_CALL:      o_mem_wr = 1'b1;
        default:               o_mem_wr = 1'b0;
      endcase
    end
  end

  // Handshake and state outputs.
  assign o_mem_addr            = y_r;
  assign o_mem_wdata           = wdata_r;
  assign o_busy                = (state_r != mrx_pkg::ST_IDLE);
  assign o_done                = (state_r == mrx_pkg::ST_DONE);
  assign o_int_en              = int_en_r;
  assign o_int_take            = int_en_r && int_req_s && (state_r == mrx_pkg::ST_IDLE);
  assign o_accumulator_reg     = acc_r;
  assign o_program_counter_reg = prog_cnt_r;

  // Checks on the executor's own outputs.
  a_and_result: assert property (@(posedge i_mclk) disable iff (!rst_n_r)
    (i_ce && o_done && op_r == mrx_pkg::OP_AND) |=> (acc_r == ($past(acc_r) & $past(mbuf_r))))
    else $error("and result wrong");
  a_add_result: assert property (@(posedge i_mclk) disable iff (!rst_n_r)
    (i_ce && o_done && op_r == mrx_pkg::OP_ADD) |=> (acc_r == 12'($past(acc_r) + $past(mbuf_r))))
    else $error("add result wrong");
  a_inc_write: assert property (@(posedge i_mclk) disable iff (!rst_n_r)
    (o_done && op_r == mrx_pkg::OP_INC_SKIP)
      |-> (o_mem_wr && o_mem_wdata == 12'(mbuf_r + 12'h001)))
    else $error("increment write wrong");
  a_inc_skip: assert property (@(posedge i_mclk) disable iff (!rst_n_r)
    (i_ce && o_done && op_r == mrx_pkg::OP_INC_SKIP && mbuf_r == 12'hfff)
      |=> (prog_cnt_r == 12'($past(prog_cnt_r) + 12'h002)))
    else $error("skip not taken");
  a_store_clear: assert property (@(posedge i_mclk) disable iff (!rst_n_r)
    (i_ce && o_done && op_r == mrx_pkg::OP_STORE_CLR)
      |-> (o_mem_wr && o_mem_wdata == acc_r) ##1 (acc_r == 12'h000))
    else $error("deposit and clear wrong");
  a_call_write: assert property (@(posedge i_mclk) disable iff (!rst_n_r)
    (o_done && op_r == mrx_pkg::OP_CALL)
      |-> (o_mem_wr && o_mem_wdata == 12'(prog_cnt_r + 12'h001)))
    else $error("return address wrong");
  a_call_target: assert property (@(posedge i_mclk) disable iff (!rst_n_r)
    (i_ce && o_done && op_r == mrx_pkg::OP_CALL) |=> (prog_cnt_r == 12'($past(y_r) + 12'h001)))
    else $error("subroutine target wrong");
  a_jump_target: assert property (@(posedge i_mclk) disable iff (!rst_n_r)
    (i_ce && o_done && op_r == mrx_pkg::OP_JUMP) |=> (prog_cnt_r == $past(y_r)))
    else $error("jump target wrong");
  a_int_gate: assert property (@(posedge i_mclk) disable iff (!rst_n_r)
    o_int_take |-> (o_int_en && int_req_s))
    else $error("interrupt taken while disabled");
  a_int_on_sets: assert property (@(posedge i_mclk) disable iff (!rst_n_r)
    (i_ce && i_start && !o_busy && i_instr == mrx_pkg::XFER_INT_ON) |=> o_int_en)
    else $error("interrupt enable not set");
  a_int_off_clears: assert property (@(posedge i_mclk) disable iff (!rst_n_r)
    (i_ce && i_start && !o_busy && i_instr == mrx_pkg::XFER_INT_OFF) |=> !o_int_en)
    else $error("interrupt enable not cleared");
endmodule // mrx_exec

//--- design/mrx_sync.sv
// Two flip-flop synchroniser for a level arriving from outside the clock domain.
`timescale 1ns/10ps
module mrx_sync (
  // Clock, reset and enable.
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  input  wire logic i_ce,
  // Level in and out.
  input  wire logic i_async,
  output logic      o_sync
);
  logic meta_r;

  // First stage feeds only the second stage.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_r <= 1'b0;
      o_sync <= 1'b0;
    end else if (i_ce) begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule // mrx_sync

//--- dv/memref_instruction_execute_tb.sv
// Self-checking bench for the memory-reference executor against a behavioural model.
`timescale 1ns/10ps
module memref_instruction_execute_tb;
  logic        i_mclk, i_resetn, i_ce, i_start, i_int_req;
  logic [11:0] i_instr, i_addr_y, rdata, maddr, wdata, acc, prog_cnt, acc_m, prog_m;
  logic        busy, done, rd, wr, take, int_en;
  integer      failures, compares, seed, i;
  // Executor with short instruction times.
  mrx_exec #(.CYC_SHORT(4), .CYC_MID(6), .CYC_LONG(8)) dut (.i_mclk(i_mclk),
    .i_resetn(i_resetn), .i_ce(i_ce), .i_start(i_start), .i_instr(i_instr),
    .i_addr_y(i_addr_y), .o_busy(busy), .o_done(done), .o_mem_addr(maddr),
    .o_mem_wdata(wdata), .o_mem_rd(rd), .o_mem_wr(wr), .i_mem_rdata(rdata),
    .i_int_req(i_int_req), .o_int_take(take), .o_int_en(int_en),
    .o_accumulator_reg(acc), .o_program_counter_reg(prog_cnt));
  mrx_mem_model mem_u (.i_mclk(i_mclk), .i_addr(maddr), .i_wdata(wdata), .i_rd(rd),
    .i_wr(wr), .o_rdata(rdata));
  // Clock at 125 MHz.
  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end
  // Compare one value and count it.
  task chk(input logic [11:0] seen, input logic [11:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Print counts and the verdict, then stop.
  task test_done;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task tick;
    @(posedge i_mclk);
    #1;
  endtask
  // Present one request for a single cycle.
  task go(input logic [11:0] ins, input logic [11:0] y);
    i_instr = ins;
    i_addr_y = y;
    i_start = 1'b1;
    tick;
    i_start = 1'b0;
  endtask
  // Run one instruction and compare timing, registers and memory with the model.
  task run(input logic [11:0] ins, input logic [11:0] y);
    logic [11:0] m;
    int          n, k;
    m = mem_u.mem[y];
    n = 6;
    prog_m = prog_m + 12'h001;
    case (ins[11:9])
      3'h0: acc_m = acc_m & m;
      3'h1: acc_m = acc_m + m;
      3'h2: begin
        m = m + 12'h001;
        if (m == 12'h000) prog_m = prog_m + 12'h001;
      end
      3'h3: begin
        m = acc_m;
        acc_m = 12'h000;
      end
      3'h4: begin
        m = prog_m;
        prog_m = y + 12'h001;
        n = 8;
      end
      default: begin
        prog_m = y;
        n = 4;
      end
    endcase
    go(ins, y);
    chk(maddr, y);
    // The read cycle after the take counts as one, so done shows in the n-th cycle.
    k = 1;
    while (done !== 1'b1 && k < 20) begin
      tick;
      k = k + 1;
    end
    chk(12'(k), 12'(n));
    tick;
    chk(acc, acc_m);
    chk(prog_cnt, prog_m);
    chk(mem_u.mem[y], m);
  endtask
  // Watchdog against a hang.
  initial begin
    #400000;
    failures = failures + 1;
    test_done;
  end
  // Main sequence.
  initial begin
    failures = 0;
    compares = 0;
    seed = 18;
    i_resetn = 1'b0;
    i_ce = 1'b1;
    i_start = 1'b0;
    i_int_req = 1'b0;
    i_instr = 12'h000;
    i_addr_y = 12'h000;
    acc_m = 12'h000;
    prog_m = 12'h000;
    repeat (2) @(posedge i_mclk);
    #1;
    i_resetn = 1'b1;
    repeat (3) tick;
    // Skip case on a wrapping increment, then random back-to-back work.
    mem_u.mem[12'h010] = 12'hfff;
    run(12'h400, 12'h010);
    for (i = 0; i < 30; i = i + 1) begin
      i_addr_y = 12'($random(seed));
      mem_u.mem[i_addr_y] = 12'($random(seed));
      run({3'(({$random(seed)}) % 6), 9'h000}, i_addr_y);
    end
    // A low clock enable freezes the executor, so a jump request is not taken.
    i_ce = 1'b0;
    go(12'ha00, 12'h0ab);
    chk({11'h000, busy}, 12'h000);
    chk(prog_cnt, prog_m);
    i_ce = 1'b1;
    tick;
    // Opcode 7 is ignored.
    go(12'he00, 12'h000);
    chk({11'h000, busy}, 12'h000);
    tick;
    // The request is held as a steady level while enable is switched.
    i_int_req = 1'b1;
    go(12'hc01, 12'h000);
    repeat (3) tick;
    chk({11'h000, int_en}, 12'h001);
    chk({11'h000, take}, 12'h001);
    go(12'hc02, 12'h000);
    repeat (2) tick;
    chk({10'h000, int_en, take}, 12'h000);
    test_done;
  end
endmodule // memref_instruction_execute_tb

//--- dv/mrx_mem_model.sv
// Behavioural core memory that answers the executor's read and write strobes.
`timescale 1ns/10ps
module mrx_mem_model (
  // Clock.
  input  wire logic        i_mclk,
  // Access from the executor.
  input  wire logic [11:0] i_addr,
  input  wire logic [11:0] i_wdata,
  input  wire logic        i_rd,
  input  wire logic        i_wr,
  // Read data back.
  output logic      [11:0] o_rdata
);
  logic [11:0] mem [0:4095];
  logic [11:0] last_r;
  // Writes land at the edge of the strobe; the last read word is kept.
  always_ff @(posedge i_mclk) begin
    if (i_wr) mem[i_addr] <= i_wdata;
    if (i_rd) last_r <= mem[i_addr];
  end
  // Outside a read the data lines show the inverse of the last word, never a stale copy.
  assign o_rdata = i_rd ? mem[i_addr] : ~last_r;
endmodule // mrx_mem_model

//--- shared/mrx_pkg.sv
// Package with opcodes, states, timing and reset values of the memory-reference executor.
package mrx_pkg;
  // Word and address width of the processor.
  localparam int WORD_W = 12;
  // Operation codes held in the top three bits of an instruction.
  localparam logic [2:0] OP_AND       = 3'h0;
  localparam logic [2:0] OP_ADD       = 3'h1;
  localparam logic [2:0] OP_INC_SKIP  = 3'h2;
  localparam logic [2:0] OP_STORE_CLR = 3'h3;
  localparam logic [2:0] OP_CALL      = 3'h4;
  localparam logic [2:0] OP_JUMP      = 3'h5;
  localparam logic [2:0] OP_XFER      = 3'h6;
  // Interrupt on and off transfer codes (octal 6001 and 6002).
  localparam logic [11:0] XFER_INT_ON  = 12'hc01;
  localparam logic [11:0] XFER_INT_OFF = 12'hc02;
  // Values after reset.
  localparam logic [11:0] ACC_RST      = 12'h000;
  localparam logic [11:0] PROG_CNT_RST = 12'h000;
  // Clock period and instruction times.
  localparam int CLK_PERIOD_NS = 8;
  localparam int T_SHORT_US    = 12;
  localparam int T_MID_US      = 18;
  localparam int T_LONG_US     = 24;
  // Cycle counts; a longest time rounds down.
  localparam int CYC_SHORT = (T_SHORT_US * 1000) / CLK_PERIOD_NS;
  localparam int CYC_MID   = (T_MID_US * 1000) / CLK_PERIOD_NS;
  localparam int CYC_LONG  = (T_LONG_US * 1000) / CLK_PERIOD_NS;
  // Execution phases.
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b10,
    ST_DONE  = 2'b11
  } mrx_state_t;
endpackage
